// ==== acsr_pkg.sv ====
// Shared constants and types for the converter cycle controller and serial readout
package acsr_pkg;

  // System clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  // Power-on reset pulse length in milliseconds and in system clock cycles
  localparam int unsigned POR_TIME_MS     = 1;
  localparam int unsigned POR_CYCLES      = int'((64'(POR_TIME_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS));
  // Conversion length in conversion clock ticks, and the full-scale calibration slice at its end
  localparam int unsigned CONV_TICKS      = 2560;
  localparam int unsigned FS_CAL_TICKS    = 256;
  // Half period of the internally generated serial clock, in system clock cycles
  localparam int unsigned SCK_HALF_CYCLES = 10;
  // Cycles without an edge on the frequency pin before it is taken as a fixed level
  localparam int unsigned EXTOSC_TIMEOUT  = 64;

  // Output word layout
  localparam int unsigned WORD_BITS       = 24;
  localparam int unsigned DATA_BITS       = 21;
  localparam int unsigned POS_EOC         = 23;
  localparam int unsigned POS_FIXED_LOW   = 22;
  localparam int unsigned POS_SIGN        = 21;
  localparam int unsigned BIT_CNT_W       = 5;

  // Serial clock pin level that selects internal serial clock operation
  localparam logic        SCK_LEVEL_INTERNAL = 1'b1;

  // Number of inputs passed through the synchroniser bank: four pins and two link-domain toggles
  localparam int unsigned SYNC_N          = 6;
  // Synchroniser reset levels; chip select rests high so no false select follows reset
  localparam logic [SYNC_N-1:0] SYNC_IDLE = 6'h04;

  typedef enum logic [1:0] {
    ST_POR,
    ST_CONV,
    ST_SLEEP,
    ST_OUTPUT
  } acsr_state_type;

endpackage

// ==== acsr_top.sv ====
// Conversion cycle controller and 24-bit serial readout with internal or external serial clock
// Function
// - Cycle conversion, sleep, data output, then back to conversion.
// - After conversion enter sleep; stay while chip select is high, low power.
// - Hold finished result unchanged in static shift register during sleep.
// - Chip select low wakes device and moves it into data output.
// - Chip select high before first rising clock returns to sleep, result kept.
// - After first rising clock shift out; chip select high aborts, new conversion.
// - Output word always belongs to the conversion just completed.
// - Serial output changes on falling clock; host samples on rising.
// - Output ends after 24 bits or chip select high; conversion restarts.
// - Clock source and free-running chosen by pin timing only, no registers.
// - Full-scale calibration inside each conversion, invisible to sequencing; no offset calibration.
// - Held in internal reset while supply is below threshold.
// - Supply recovery produces a 1 ms power-on reset clearing all registers except synchronisers, their edge history and link-domain state.
// - After power-on reset, start a normal conversion and regular cycle.
// - Out-of-range inputs give distinct overrange or underrange codes.
// - Serial clock mode taken from clock pin level at power-up or chip select fall.
// - Data pin floats with chip select high; shows status during conversion and sleep.
// - Word: end-of-conversion flag, fixed low bit, sign, 21-bit result MSB first.
// - Internal oscillator when frequency pin fixed; external clock when it toggles.
`timescale 1ns/100ps
module acsr_top #(
  parameter int unsigned POR_LEN = acsr_pkg::POR_CYCLES
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic                          i_supply_ok,
  input  wire logic                          i_freq_select_pin,
  input  wire logic                          i_cs_n,
  input  wire logic                          i_sck,
  output logic                               o_sck,
  output logic                               o_sck_oe,
  output logic                               o_sdo,
  output logic                               o_sdo_oe,
  input  wire logic [acsr_pkg::DATA_BITS-1:0] i_mod_result,
  input  wire logic                          i_mod_sign,
  input  wire logic                          i_mod_over,
  input  wire logic                          i_mod_under,
  output logic                               o_low_power,
  output logic                               o_conv_busy,
  output logic                               o_fs_cal_active,
  output logic                               o_ext_osc,
  output logic                               o_int_sck_mode
);
  import acsr_pkg::*;

  // Picks one bit of the output word; bit WORD_BITS-1 leaves first
  function automatic logic word_bit(input logic [WORD_BITS-1:0] w, input logic [BIT_CNT_W-1:0] idx);
    word_bit = w[idx];
  endfunction

  acsr_state_type          state_reg;
  logic [17:0]             por_cnt_reg;
  logic [15:0]             conv_cnt_reg;
  logic [WORD_BITS-1:0]    word_reg;
  logic                    int_mode_reg;
  logic                    started_reg;
  logic                    ext_osc_reg;
  logic [6:0]              osc_idle_reg;
  logic [3:0]              div_cnt_reg;
  logic [BIT_CNT_W-1:0]    int_bit_reg;
  logic                    int_done_reg;
  logic                    sdo_sys_reg;
  logic                    sdo_oe_reg;
  logic                    sck_reg;
  logic                    sck_oe_reg;
  logic                    low_power_reg;
  logic                    cal_reg;
  logic [SYNC_N-1:0]       sync1_reg;
  logic [SYNC_N-1:0]       sync2_reg;
  logic [SYNC_N-1:0]       sync3_reg;
  logic [SYNC_N-1:0]       filt_reg;
  logic [SYNC_N-1:0]       filt_prev_reg;
  logic [SYNC_N-1:0]       raw_in;
  logic                    supply_f;
  logic                    freq_f;
  logic                    cs_f;
  logic                    sck_f;
  logic                    lk_rise_evt;
  logic                    lk_done_evt;
  logic                    cs_fall_evt;
  logic                    freq_rise_evt;
  logic                    rst_all;
  logic                    tick;
  logic                    conv_end;
  logic                    out_started;
  logic                    out_done;
  logic                    por_end;
  // Link-domain state, cleared by chip select high since the serial clock may be stopped
  logic [BIT_CNT_W-1:0]    lk_cnt_reg;
  logic                    lk_sdo_reg;
  logic                    lk_rise_tgl_reg;
  logic                    lk_done_tgl_reg;

  // Pin inputs and link-domain toggles enter the system domain
  assign raw_in = {lk_done_tgl_reg, lk_rise_tgl_reg, i_sck, i_cs_n, i_freq_select_pin, i_supply_ok};

  // Three-stage synchroniser per input; a change is accepted once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          sync1_reg[g] <= SYNC_IDLE[g];
          sync2_reg[g] <= SYNC_IDLE[g];
          sync3_reg[g] <= SYNC_IDLE[g];
          filt_reg[g]  <= SYNC_IDLE[g];
        end else begin
          sync1_reg[g] <= raw_in[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
          if (sync2_reg[g] == sync3_reg[g]) begin
            filt_reg[g] <= sync3_reg[g];
          end
        end
      end
    end
  endgenerate

  // Previous filtered values for edge and toggle detection
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      filt_prev_reg <= SYNC_IDLE;
    end else begin
      filt_prev_reg <= filt_reg;
    end
  end

  assign supply_f      = filt_reg[0];
  assign freq_f        = filt_reg[1];
  assign cs_f          = filt_reg[2];
  assign sck_f         = filt_reg[3];
  assign freq_rise_evt = freq_f & ~filt_prev_reg[1];
  assign cs_fall_evt   = ~cs_f & filt_prev_reg[2];
  assign lk_rise_evt   = filt_reg[4] ^ filt_prev_reg[4];
  assign lk_done_evt   = filt_reg[5] ^ filt_prev_reg[5];

  // Low supply holds every register except the synchroniser bank, its edge history and the link-domain state in reset; the pulse timer starts when it recovers
  assign rst_all = i_sys_rst | ~supply_f;

  // Conversion clock tick: every system cycle, or each rising edge of an external oscillator
  assign tick        = ext_osc_reg ? freq_rise_evt : 1'b1;
  assign conv_end    = (state_reg == ST_CONV) && tick && (conv_cnt_reg == 16'(CONV_TICKS - 1));
  assign por_end     = (state_reg == ST_POR) && (por_cnt_reg == 18'(POR_LEN - 1));
  assign out_started = started_reg | (int_mode_reg ? (sck_reg == 1'b1) : lk_rise_evt);
  assign out_done    = int_mode_reg ? int_done_reg : lk_done_evt;

  // Main cycle sequencer
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      state_reg <= ST_POR;
    end else begin
      case (state_reg)
        ST_POR: begin
          if (por_end) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_end) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!cs_f) begin
            state_reg <= ST_OUTPUT;
          end
        end
        ST_OUTPUT: begin
          if (cs_f) begin
            state_reg <= started_reg ? ST_CONV : ST_SLEEP;
          end else if (started_reg && out_done) begin
            state_reg <= ST_CONV;
          end
        end
        default: begin
          state_reg <= ST_POR;
        end
      endcase
    end
  end

  // Power-on reset pulse timer
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      por_cnt_reg <= '0;
    end else if (state_reg == ST_POR && !por_end) begin
      por_cnt_reg <= por_cnt_reg + 18'h00001;
    end
  end

  // Conversion tick counter; calibration occupies a fixed tail slice, so timing never shifts
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      conv_cnt_reg <= '0;
      cal_reg      <= 1'b0;
    end else if (state_reg == ST_CONV) begin
      if (tick) begin
        conv_cnt_reg <= conv_end ? 16'h0000 : conv_cnt_reg + 16'h0001;
      end
      // Looks one tick ahead so the slice lasts exactly FS_CAL_TICKS ticks
      cal_reg <= !conv_end && ((conv_cnt_reg >= 16'(CONV_TICKS - FS_CAL_TICKS)) ||
                               (tick && conv_cnt_reg == 16'(CONV_TICKS - FS_CAL_TICKS - 1)));
    end else begin
      conv_cnt_reg <= '0;
      cal_reg      <= 1'b0;
    end
  end

  // Result capture at conversion end; held untouched until the next conversion ends
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      word_reg <= '0;
    end else if (conv_end) begin
      word_reg[POS_EOC]       <= 1'b0;
      word_reg[POS_FIXED_LOW] <= 1'b0;
      if (i_mod_over) begin
        word_reg[POS_SIGN:0] <= {2'b11, {(DATA_BITS-1){1'b0}}};
      end else if (i_mod_under) begin
        word_reg[POS_SIGN:0] <= {2'b00, {(DATA_BITS-1){1'b1}}};
      end else begin
        word_reg[POS_SIGN:0] <= {i_mod_sign, i_mod_result};
      end
    end
  end

  // Serial clock mode: pin level at power-up exit or at each chip select fall
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      int_mode_reg <= 1'b0;
    end else if (por_end || cs_fall_evt) begin
      int_mode_reg <= (sck_f == SCK_LEVEL_INTERNAL);
    end
  end

  // First rising serial clock edge seen in the current output state
  always_ff @(posedge i_clk) begin
    if (rst_all || state_reg != ST_OUTPUT) begin
      started_reg <= 1'b0;
    end else if (!cs_f && out_started) begin
      started_reg <= 1'b1;
    end
  end

  // External oscillator detect: any edge selects it, a quiet spell returns to internal
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      ext_osc_reg  <= 1'b0;
      osc_idle_reg <= '0;
    end else if (freq_f != filt_prev_reg[1]) begin
      ext_osc_reg  <= 1'b1;
      osc_idle_reg <= '0;
    end else if (osc_idle_reg == 7'(EXTOSC_TIMEOUT - 1)) begin
      ext_osc_reg <= 1'b0;
    end else begin
      osc_idle_reg <= osc_idle_reg + 7'h01;
    end
  end

  // Internal serial clock generator and bit counter; data moves on the falling edge
  always_ff @(posedge i_clk) begin
    if (rst_all || state_reg != ST_OUTPUT || !int_mode_reg || cs_f) begin
      div_cnt_reg  <= '0;
      sck_reg      <= 1'b0;
      int_bit_reg  <= 5'(POS_EOC);
      int_done_reg <= 1'b0;
    end else if (!int_done_reg) begin
      if (div_cnt_reg == 4'(SCK_HALF_CYCLES - 1)) begin
        div_cnt_reg <= '0;
        sck_reg     <= ~sck_reg;
        if (sck_reg) begin
          if (int_bit_reg == 5'h00) begin
            int_done_reg <= 1'b1;
          end else begin
            int_bit_reg <= int_bit_reg - 5'h01;
          end
        end
      end else begin
        div_cnt_reg <= div_cnt_reg + 4'h1;
      end
    end
  end

  // Status and data on the system side, pin enables and low-power flag
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      sdo_sys_reg   <= 1'b1;
      sdo_oe_reg    <= 1'b0;
      sck_oe_reg    <= 1'b0;
      low_power_reg <= 1'b0;
    end else begin
      sdo_oe_reg    <= ~cs_f;
      sck_oe_reg    <= (state_reg == ST_OUTPUT) && int_mode_reg && !cs_f;
      low_power_reg <= (state_reg == ST_SLEEP) && cs_f;
      case (state_reg)
        ST_OUTPUT: sdo_sys_reg <= int_mode_reg ? word_bit(word_reg, int_bit_reg) : word_reg[POS_EOC];
        ST_SLEEP:  sdo_sys_reg <= 1'b0;
        default:   sdo_sys_reg <= 1'b1;
      endcase
    end
  end

  // Rising-edge toggle tells the system side that clocking has begun
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      lk_rise_tgl_reg <= 1'b0;
    end else begin
      lk_rise_tgl_reg <= ~lk_rise_tgl_reg;
    end
  end

  // External clock shifter: next bit presented on each falling edge, ignored while deselected
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      lk_cnt_reg      <= '0;
      lk_sdo_reg      <= 1'b0;
      lk_done_tgl_reg <= 1'b0;
    end else if (lk_cnt_reg == 5'(WORD_BITS - 1)) begin
      lk_cnt_reg      <= '0;
      lk_sdo_reg      <= 1'b1;
      lk_done_tgl_reg <= ~lk_done_tgl_reg;
    end else begin
      lk_cnt_reg <= lk_cnt_reg + 5'h01;
      lk_sdo_reg <= word_bit(word_reg, 5'(POS_FIXED_LOW) - lk_cnt_reg);
    end
  end

  // Status outputs, registered one system cycle behind their internal sources
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_low_power     <= 1'b0;
      o_conv_busy     <= 1'b0;
      o_fs_cal_active <= 1'b0;
      o_ext_osc       <= 1'b0;
      o_int_sck_mode  <= 1'b0;
    end else begin
      o_low_power     <= low_power_reg;
      o_conv_busy     <= (state_reg == ST_CONV);
      o_fs_cal_active <= cal_reg;
      o_ext_osc       <= ext_osc_reg;
      o_int_sck_mode  <= int_mode_reg;
    end
  end

  // Pin drivers; word bits are static while they are read across the clock boundary
  assign o_sck    = sck_reg;
  assign o_sck_oe = sck_oe_reg;
  assign o_sdo_oe = sdo_oe_reg;
  assign o_sdo    = (!int_mode_reg && state_reg == ST_OUTPUT && lk_cnt_reg != 5'h00) ? lk_sdo_reg : sdo_sys_reg;

endmodule

// ==== acsr_top_monitor.sv ====
// Checker for the converter cycle and the serial readout pins
`timescale 1ns/100ps
module acsr_top_monitor
  import acsr_pkg::*;
#(
  parameter int unsigned POR_LEN = 20
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic o_sck,
  input wire logic o_sck_oe,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  input wire logic o_low_power,
  input wire logic o_conv_busy,
  input wire logic o_fs_cal_active,
  input wire logic o_ext_osc,
  input wire logic o_int_sck_mode
);
  logic [11:0] busy_cnt_reg;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Length of the current busy run; external oscillator runs are not timed
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      busy_cnt_reg <= 12'h000;
    end else begin
      busy_cnt_reg <= o_conv_busy ? busy_cnt_reg + 12'h001 : 12'h000;
    end
  end

  a_oe_cs_high: assert property (i_cs_n [*8] |-> !o_sdo_oe)
    else $error("data pin driven while deselected");
  a_oe_cs_low: assert property ((!i_cs_n && o_conv_busy) [*8] |-> o_sdo_oe)
    else $error("status not driven while selected");
  a_cal_in_conv: assert property (o_fs_cal_active |-> o_conv_busy)
    else $error("calibration outside conversion");
  a_sleep_idle: assert property (o_low_power |-> !o_conv_busy && !o_fs_cal_active)
    else $error("low power while converting");
  a_conv_length: assert property ($fell(o_conv_busy) && !o_ext_osc |-> busy_cnt_reg == 12'(CONV_TICKS))
    else $error("conversion length wrong");
  a_eoc_low: assert property ($fell(o_conv_busy) && o_sdo_oe |-> ##[0:3] !o_sdo)
    else $error("end of conversion flag not low");
  a_sck_int_only: assert property (o_sck_oe |-> o_int_sck_mode)
    else $error("clock driven in external mode");
  a_sck_half: assert property ($rose(o_sck) |-> o_sck [*8] ##2 o_sck ##1 !o_sck)
    else $error("internal clock half period wrong");
  a_sdo_hold_high: assert property (o_sck_oe && o_sck && $past(o_sck) |-> $stable(o_sdo))
    else $error("data changed while clock high");

  c_eoc_seen: cover property ($fell(o_conv_busy) && o_sdo_oe);
  c_int_clock: cover property (o_sck_oe && o_sck);
  c_sleep: cover property ($rose(o_low_power));
  c_cal: cover property (o_fs_cal_active);
endmodule

bind acsr_top acsr_top_monitor #(.POR_LEN(POR_LEN)) u_mon (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
  .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_low_power(o_low_power), .o_conv_busy(o_conv_busy),
  .o_fs_cal_active(o_fs_cal_active), .o_ext_osc(o_ext_osc), .o_int_sck_mode(o_int_sck_mode)
);

// ==== acsr_host_model.sv ====
// Host model that frames reads on the three-wire link
`timescale 1ns/100ps
module acsr_host_model (
  input  wire logic i_sck_line,
  input  wire logic i_sdo_line,
  output logic      o_cs_n,
  output logic      o_sck
);
  logic tmo;
  logic tail;

  // Idle: deselected, clock parked low so the link clock stands still
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    tmo = 1'b0;
    tail = 1'b0;
  end

  // Short select with no clock edges, reads only the status bit
  task peek(output logic b);
    o_cs_n = 1'b0;
    #60;
    b = i_sdo_line;
    o_cs_n = 1'b1;
    #20;
  endtask

  // Read n bits; clock level before select picks the mode, high stands in for the pull-up
  task xfer(input int n, input bit intm, output logic [23:0] w);
    int k;
    int t;
    w = 24'h000000;
    o_sck = intm;
    #60;
    o_cs_n = 1'b0;
    #50;
    for (t = 0; t < 4000 && !intm && i_sdo_line !== 1'b0; t++) #5; // Wait out a running conversion
    if (t == 4000) tmo = 1'b1;
    // Internal clock: start watching before its first rising edge, or bit 23 is missed
    if (!intm) #50;
    for (k = 0; k < n; k++) begin
      if (intm) begin
        for (t = 0; t < 400 && i_sck_line !== 1'b0; t++) #1;
        for (; t < 400 && i_sck_line !== 1'b1; t++) #1;
        if (t == 400) tmo = 1'b1;
      end else begin
        o_sck = 1'b1;
      end
      w = {w[22:0], i_sdo_line};
      if (!intm) begin
        #7.5;
        o_sck = 1'b0;
        #7.5;
      end
    end
    #100;
    tail = i_sdo_line;
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    #20;
  endtask
endmodule

// ==== test_adc_cycle_serial_readout.sv ====
// Self-checking bench: random conversions read back through the host model
`timescale 1ns/100ps
module test_adc_cycle_serial_readout;
  import acsr_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        supply_ok = 1'b1;
  logic        freq_pin;
  logic [20:0] mr;
  logic        ms, mo, mu, b;
  logic        sck_d, sck_oe, sdo_d, sdo_oe, lp, busy, cal, ext_osc, int_mode;
  logic        sdo_last = 1'b0;
  logic [31:0] seed = 32'h5A08;
  logic [23:0] ex, w;
  wire logic   cs_n, host_sck, sck_w, sdo_w;
  int          err_count = 0;
  int          n_tests = 0;
  int          i;
  int          cal_run = 0;
  int          cal_last = 0;

  always #2.5 clk = ~clk;

  // Pin levels; a released data line shows the inverse of its last driven value
  assign sck_w = sck_oe ? sck_d : host_sck;
  assign sdo_w = sdo_oe ? sdo_d : ~sdo_last;
  always @(posedge clk) if (sdo_oe) sdo_last <= sdo_d;

  // Calibration cycles of the running conversion, and of the last finished one
  always @(posedge clk) begin
    cal_run <= busy ? cal_run + int'(cal) : 0;
    if (!busy && cal_run != 0) cal_last <= cal_run;
  end

  // Short power-on pulse keeps the run brief
  acsr_top #(.POR_LEN(20)) uut (
    .i_clk(clk), .i_sys_rst(rst), .i_supply_ok(supply_ok), .i_freq_select_pin(freq_pin),
    .i_cs_n(cs_n), .i_sck(sck_w), .o_sck(sck_d), .o_sck_oe(sck_oe), .o_sdo(sdo_d), .o_sdo_oe(sdo_oe),
    .i_mod_result(mr), .i_mod_sign(ms), .i_mod_over(mo), .i_mod_under(mu), .o_low_power(lp),
    .o_conv_busy(busy), .o_fs_cal_active(cal), .o_ext_osc(ext_osc), .o_int_sck_mode(int_mode)
  );
  acsr_host_model host (.i_sck_line(sck_w), .i_sdo_line(sdo_w), .o_cs_n(cs_n), .o_sck(host_sck));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Over-range wins when both range flags are raised
  function logic [23:0] exp_word(logic [20:0] r, logic s, logic o, logic u);
    if (o) return 24'h300000;
    if (u) return 24'h0FFFFF;
    return {2'b00, s, r};
  endfunction

  task chk_w(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task chk_b(input logic g, input logic e);
    chk_w({23'h000000, g}, {23'h000000, e});
  endtask

  task give_verdict();
    $display("errors=%0d tests=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Bounded wait for busy or low power to go high; running out counts as a mismatch
  task wt(input bit on_busy, input int n);
    int k;
    for (k = 0; k < n && (on_busy ? busy : lp) !== 1'b1; k++) @(posedge clk);
    if (k == n) begin
      chk_b(1'b0, 1'b1);
      give_verdict();
    end
    #1;
  endtask

  // New modulator outcome, held until this conversion captures it
  task load(input int k);
    @(posedge clk);
    #1;
    {ms, mr} = 22'(rnd());
    if (k == 6) mr = 21'h1FFFFF;
    mo = (k == 1) || (k == 5);
    mu = (k == 2) || (k == 5);
    ex = exp_word(mr, ms, mo, mu);
  endtask

  initial begin
    freq_pin = 1'(rnd());
    {ms, mr, mo, mu} = 24'h000000;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    for (i = 0; i < 8; i++) begin
      wt(1'b1, 100);
      if (i == 0) chk_b(ext_osc, 1'b0);
      load(i);
      if (i == 3) begin
        host.peek(b);
        chk_b(b, 1'b1);
      end
      if (i != 0) wt(1'b0, 3000);
      if (i != 0) chk_w(24'(cal_last), 24'(FS_CAL_TICKS));
      if (i == 3) begin
        host.peek(b);
        chk_b(b, 1'b0);
        wt(1'b0, 20);
        chk_b(busy, 1'b0);
      end
      if (i == 6) begin
        supply_ok = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk_b(lp, 1'b0);
        supply_ok = 1'b1;
        wt(1'b1, 60);
        load(i);
        wt(1'b0, 3000);
      end
      host.xfer((i == 5) ? 8 : 24, (i == 4) || (i == 7), w);
      chk_w(w, ex >> ((i == 5) ? 16 : 0));
      chk_b(host.tmo, 1'b0);
      chk_b(int_mode, (i == 4) || (i == 7));
      if (i != 5) chk_b(host.tail, 1'b1);
    end
    wt(1'b1, 100);
    give_verdict();
  end
endmodule
